// ### hw/fsw_pkg.sv
// constants, types and state layout of the fail-safe watchdog unit
// Summary of operation
// RULE1: watchdog is a 15-bit up-counter.
// RULE2: count rate is oscillator divided by 12 or by 384, selectable.
// RULE3: at 16 MHz the timeout spans about 192 us to 0.79 s.
// RULE4: software programs only the top seven counter bits; low bits not loadable.
// RULE5: counting starts on the software start bit or the hardware start pin.
// RULE6: a running watchdog cannot be stopped by software in active mode.
// RULE7: overflow without refresh raises an internal reset.
// RULE8: a valid refresh copies the reload value into the top seven bits.
// RULE9: software refreshes by arm bit then start bit, in back-to-back instructions.
// RULE10: a readable flag tells watchdog reset from external reset.
// RULE11: counter holds its value in idle and power-down modes.
// RULE12: slow main oscillator selects the RC clock and holds reset.
// RULE13: once main is faster again, hold reset about 0.5 ms, then release.
// RULE14: after hardware power-down, supervisor restarts exactly as when monitoring.
// RULE15: after power-on, reset runs from the RC clock before main starts.
// RULE16: arm without start in the next instruction is void: no reload, disarm.
package fsw_pkg;
    localparam int WDT_WIDTH = 15;
    localparam int RELOAD_WIDTH = 7;
    localparam int LOW_WIDTH = WDT_WIDTH - RELOAD_WIDTH;
    localparam logic [WDT_WIDTH-1:0] WDT_MAX = 15'h7fff;
    localparam logic [WDT_WIDTH-1:0] WDT_RESET_VAL = 15'h0000;
    localparam int DIV_FAST = 12;
    localparam int DIV_SLOW = 384;
    localparam logic [3:0] FAST_LAST = 4'(DIV_FAST - 1);
    localparam logic [4:0] SLOW_LAST = 5'(DIV_SLOW / DIV_FAST - 1);
    localparam int CLK_PERIOD_NS = 40;
    localparam int STAB_TIME_US = 500;
    localparam int STAB_CYCLES = (STAB_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam logic [3:0] RC_WINDOW = 4'h8;
    localparam logic [7:0] MAIN_SAT = 8'hff;
    // lane positions of the synchronised pin inputs
    localparam int LN_START = 0;
    localparam int LN_MAIN = 1;
    localparam int LN_RC = 2;
    localparam int LN_PD = 3;
    localparam logic [3:0] SYNC_RESET_VAL = 4'h9;

    typedef enum logic [2:0] {
        FSW_OSV_POR = 3'b000,
        FSW_OSV_FAIL = 3'b001,
        FSW_OSV_STAB = 3'b010,
        FSW_OSV_RUN = 3'b011,
        FSW_OSV_PD = 3'b100
    } fsw_osv_t;

    typedef struct packed {
        logic [WDT_WIDTH-1:0] cnt;
        logic running;
        logic armed;
        logic [3:0] pre_lo;
        logic [4:0] pre_hi;
        logic status;
        logic wdt_rst;
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] filt;
        fsw_osv_t osv;
        logic [7:0] main_cnt;
        logic [3:0] rc_cnt;
        logic [15:0] stab_cnt;
    } fsw_state_t;
endpackage

// ### hw/fsw_watchdog_unit.sv
// programmable watchdog counter and oscillator supervisor
`timescale 1ns/1ps
`default_nettype none
module fsw_watchdog_unit
    import fsw_pkg::*;
#(
    parameter int STAB_CNT = STAB_CYCLES
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic instr_i,
    input wire logic refresh_arm_bit_i,
    input wire logic watchdog_start_bit_i,
    input wire logic [RELOAD_WIDTH-1:0] watchdog_reload_value_i,
    input wire logic rate_slow_i,
    input wire logic idle_i,
    input wire logic pd_i,
    input wire logic ext_reset_i,
    input wire logic hw_watchdog_start_pin_n_i,
    input wire logic main_osc_i,
    input wire logic rc_osc_i,
    input wire logic hw_pd_n_i,
    output logic [WDT_WIDTH-1:0] wdt_count_o,
    output logic wdt_running_o,
    output logic wdt_reset_o,
    output logic watchdog_reset_status_flag_o,
    output logic osc_reset_o,
    output logic clk_sel_rc_o
);
    fsw_state_t s;
    fsw_state_t next_s;
    logic [3:0] new_filt;
    logic [3:0] rise;
    logic hold;
    logic tick_fast;
    logic tick;
    logic ovf;
    logic reload;
    logic start_req;
    logic win_end;
    logic win_fail;

    // pin qualification and the watchdog count path
    always_comb
    begin
        next_s = s;
        next_s.s1 = {hw_pd_n_i, rc_osc_i, main_osc_i, hw_watchdog_start_pin_n_i};
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        // a lane moves only when stages two and three agree
        for (int i = 0; i < 4; i++)
        begin
            new_filt[i] = (s.s2[i] == s.s3[i]) ? s.s3[i] : s.filt[i];
        end
        rise = new_filt & ~s.filt;
        next_s.filt = new_filt;
        hold = idle_i | pd_i | ~s.filt[LN_PD]; // RULE11
        tick_fast = !hold && (s.pre_lo == FAST_LAST); // RULE2
        tick = rate_slow_i ? (tick_fast && s.pre_hi == SLOW_LAST) : tick_fast; // RULE2 RULE3
        reload = instr_i && s.armed && watchdog_start_bit_i; // RULE9
        // a refresh in the overflow cycle wins, so no reset pulse follows it
        ovf = s.running && tick && (s.cnt == WDT_MAX) && !reload; // RULE7
        start_req = (instr_i && watchdog_start_bit_i) || !s.filt[LN_START]; // RULE5
        next_s.wdt_rst = ovf; // RULE7
        // prescaler runs only while the counter may count
        if (s.running && !hold)
        begin
            next_s.pre_lo = (s.pre_lo == FAST_LAST) ? 4'h0 : s.pre_lo + 4'h1;
            if (tick_fast)
            begin
                next_s.pre_hi = (s.pre_hi == SLOW_LAST) ? 5'h00 : s.pre_hi + 5'h01;
            end
        end
        if (reload)
        begin
            // only the top bits take the reload value
            next_s.cnt = {watchdog_reload_value_i, {LOW_WIDTH{1'b0}}}; // RULE8 RULE4
        end
        else if (ovf)
        begin
            next_s.cnt = WDT_RESET_VAL;
        end
        else if (s.running && tick)
        begin
            next_s.cnt = s.cnt + 15'h0001; // RULE1
        end
        // no software path clears running; only the overflow reset does
        if (ovf)
        begin
            next_s.running = 1'b0; // RULE6
        end
        else if (start_req)
        begin
            next_s.running = 1'b1; // RULE5
        end
        // arm is valid for exactly the next instruction
        if (instr_i)
        begin
            next_s.armed = refresh_arm_bit_i && !s.armed; // RULE16
        end
        // watchdog cause flag, setting wins over clearing
        if (ovf)
        begin
            next_s.status = 1'b1; // RULE10
        end
        else if (ext_reset_i)
        begin
            next_s.status = 1'b0; // RULE10
        end
        // oscillator comparison window and supervisor sequence
        win_end = rise[LN_RC] && (s.rc_cnt == RC_WINDOW - 4'h1);
        win_fail = (s.main_cnt < {4'h0, RC_WINDOW}); // RULE12
        next_s.osv = s.osv;
        next_s.stab_cnt = s.stab_cnt;
        next_s.main_cnt = s.main_cnt;
        next_s.rc_cnt = s.rc_cnt;
        if (rise[LN_RC])
        begin
            next_s.rc_cnt = win_end ? 4'h0 : s.rc_cnt + 4'h1;
        end
        if (win_end)
        begin
            next_s.main_cnt = {7'h00, rise[LN_MAIN]};
        end
        else if (rise[LN_MAIN] && s.main_cnt != MAIN_SAT)
        begin
            next_s.main_cnt = s.main_cnt + 8'h01;
        end
        case (s.osv)
            FSW_OSV_POR, FSW_OSV_FAIL:
            begin
                next_s.stab_cnt = 16'h0000;
                if (win_end && !win_fail)
                begin
                    next_s.osv = FSW_OSV_STAB; // RULE13
                end
            end
            FSW_OSV_STAB:
            begin
                next_s.stab_cnt = s.stab_cnt + 16'h0001;
                if (win_end && win_fail)
                begin
                    next_s.osv = FSW_OSV_FAIL; // RULE12
                end
                else if (s.stab_cnt == 16'(STAB_CNT - 1))
                begin
                    next_s.osv = FSW_OSV_RUN; // RULE13
                end
            end
            FSW_OSV_RUN:
            begin
                if (win_end && win_fail)
                begin
                    next_s.osv = FSW_OSV_FAIL; // RULE12
                end
            end
            FSW_OSV_PD:
            begin
                if (new_filt[LN_PD])
                begin
                    next_s.osv = FSW_OSV_FAIL; // RULE14
                end
            end
            default:
            begin
                next_s.osv = FSW_OSV_FAIL;
            end
        endcase
        // hardware power-down overrides any monitoring state
        if (!new_filt[LN_PD])
        begin
            next_s.osv = FSW_OSV_PD; // RULE14
        end
    end

    // state register; power-on starts on the rc clock in reset
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s <= '0;
            s.s1 <= SYNC_RESET_VAL;
            s.s2 <= SYNC_RESET_VAL;
            s.s3 <= SYNC_RESET_VAL;
            s.filt <= SYNC_RESET_VAL;
            s.osv <= FSW_OSV_POR; // RULE15
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs straight from state
    assign wdt_count_o = s.cnt;
    assign wdt_running_o = s.running;
    assign wdt_reset_o = s.wdt_rst;
    assign watchdog_reset_status_flag_o = s.status;
    assign osc_reset_o = (s.osv != FSW_OSV_RUN); // RULE12 RULE13 RULE15
    assign clk_sel_rc_o = (s.osv == FSW_OSV_POR) || (s.osv == FSW_OSV_FAIL); // RULE12 RULE15

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_ovf_reset: assert property (ovf |=> wdt_reset_o && !wdt_running_o) // RULE7
        else $error("overflow did not raise reset");
    a_reload_top: assert property (reload // RULE8
        |=> wdt_count_o == {$past(watchdog_reload_value_i), 8'h00})
        else $error("refresh did not load upper bits");
    a_void_seq: assert property (instr_i && s.armed && !watchdog_start_bit_i // RULE16
        |=> !s.armed && (wdt_count_o != {$past(watchdog_reload_value_i), 8'h00}
        || $past(s.cnt) == {$past(watchdog_reload_value_i), 8'h00} || $past(tick)))
        else $error("void sequence reloaded or stayed armed");
    a_hold_idle: assert property (hold && !reload |=> $stable(wdt_count_o)) // RULE11
        else $error("counter moved while halted");
    a_no_stop: assert property (wdt_running_o && !ovf |=> wdt_running_o) // RULE6
        else $error("watchdog stopped without overflow");
    a_sw_start: assert property (instr_i && watchdog_start_bit_i && !ovf |=> wdt_running_o) // RULE5
        else $error("start bit did not start watchdog");
    a_status_flag: assert property (wdt_reset_o |-> watchdog_reset_status_flag_o) // RULE10
        else $error("watchdog reset without status flag");
    a_count_step: assert property (s.running && tick && !ovf && !reload // RULE1
        |=> wdt_count_o == $past(wdt_count_o) + 15'h0001)
        else $error("counter did not step by one");
    a_fast_rate: assert property (s.running && !rate_slow_i && tick // RULE2
        ##1 (s.running && !hold && !rate_slow_i) [*8]
        ##1 (s.running && !hold && !rate_slow_i) [*4] |-> tick)
        else $error("fast rate not twelve cycles");
    a_fail_rc: assert property (s.osv == FSW_OSV_FAIL |-> clk_sel_rc_o && osc_reset_o) // RULE12
        else $error("failure state without rc clock and reset");
    a_stab_hold: assert property (s.osv == FSW_OSV_STAB && s.stab_cnt == 16'h0000 // RULE13
        |-> osc_reset_o [*8])
        else $error("reset released early in stabilisation");
endmodule
`default_nettype wire

// ### testbench/fsw_watchdog_unit_tb_top.sv
// self-checking bench of the fail-safe watchdog unit
`timescale 1ns/1ps
`default_nettype none
module fsw_watchdog_unit_tb_top;
    import fsw_pkg::*;
    localparam int STAB = 20;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic instr_i = 1'b0;
    logic arm = 1'b0;
    logic start = 1'b0;
    logic [RELOAD_WIDTH-1:0] reload = 7'h00;
    logic rate_slow_i = 1'b0;
    logic idle_i = 1'b0;
    logic pd_i = 1'b0;
    logic ext_reset_i = 1'b0;
    logic pin_n = 1'b1;
    logic main_osc = 1'b0;
    logic rc_osc = 1'b0;
    logic main_en = 1'b0;
    logic hw_pd_n = 1'b1;
    logic [WDT_WIDTH-1:0] cnt;
    logic running, wdt_rst, flag, osc_rst, sel_rc;
    logic [WDT_WIDTH-1:0] snap;
    int num_errors = 0;
    int tests_run = 0;
    int n;

    fsw_watchdog_unit #(.STAB_CNT(STAB)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
        .refresh_arm_bit_i(arm), .watchdog_start_bit_i(start),
        .watchdog_reload_value_i(reload), .rate_slow_i(rate_slow_i),
        .idle_i(idle_i), .pd_i(pd_i), .ext_reset_i(ext_reset_i),
        .hw_watchdog_start_pin_n_i(pin_n), .main_osc_i(main_osc),
        .rc_osc_i(rc_osc), .hw_pd_n_i(hw_pd_n), .wdt_count_o(cnt),
        .wdt_running_o(running), .wdt_reset_o(wdt_rst),
        .watchdog_reset_status_flag_o(flag), .osc_reset_o(osc_rst),
        .clk_sel_rc_o(sel_rc)
    );

    // system clock, rc clock always, main clock four times faster while enabled
    initial forever #20 clk_i = ~clk_i;
    initial forever #320 rc_osc = ~rc_osc;
    initial forever #80 if (main_en) main_osc = ~main_osc;

    task automatic tick(input int k = 1);
        repeat (k) @(posedge clk_i);
        #2;
    endtask

    task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // single-bit compare, no padding of the operands
    task automatic chk_bit(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // one instruction; instr_i stays high so the next one follows at once
    task automatic op(input logic a, input logic s, input logic [6:0] r);
        instr_i = 1'b1;
        arm = a;
        start = s;
        reload = r;
        tick();
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return osc_rst;
            1: return sel_rc;
            2: return wdt_rst;
            default: return running;
        endcase
    endfunction

    // bounded wait for an output to reach a level
    task automatic settle(input int lim, input int w, input logic v);
        n = 0;
        while (pick(w) !== v && n < lim)
        begin
            tick();
            n++;
        end
    endtask

    task automatic t_osc();
        main_en = 1'b1;
        settle(600, 1, 1'b0);
        chk_bit(osc_rst, 1'b1, "reset held in stab");
        settle(100, 0, 1'b0);
        chk_bit((n >= STAB) && (n <= STAB + 1), 1'b1, "stab length");
        main_en = 1'b0;
        settle(600, 0, 1'b1);
        chk_bit(sel_rc, 1'b1, "rc clock on fail");
        main_en = 1'b1;
        settle(800, 0, 1'b0);
        chk_bit(sel_rc, 1'b0, "main clock back");
        hw_pd_n = 1'b0;
        settle(20, 0, 1'b1);
        chk_bit(osc_rst, 1'b1, "reset in power-down");
        hw_pd_n = 1'b1;
        settle(800, 0, 1'b0);
        chk_bit(osc_rst, 1'b0, "restart after power-down");
    endtask

    task automatic t_wdt();
        op(1'b0, 1'b1, 7'h00);
        instr_i = 1'b0;
        chk_bit(running, 1'b1, "software start");
        op(1'b1, 1'b0, 7'h10);
        op(1'b0, 1'b1, 7'h10);
        instr_i = 1'b0;
        chk(cnt, 15'h1000, "refresh load");
        snap = cnt;
        tick(120);
        chk(cnt - snap, 15'h00a, "fast rate");
        rate_slow_i = 1'b1;
        tick(400);
        snap = cnt;
        tick(768);
        chk(cnt - snap, 15'h002, "slow rate");
        rate_slow_i = 1'b0;
        op(1'b0, 1'b0, 7'h00);
        op(1'b0, 1'b0, 7'h00);
        instr_i = 1'b0;
        chk_bit(running, 1'b1, "cannot stop");
        snap = cnt;
        op(1'b1, 1'b0, 7'h55);
        op(1'b0, 1'b0, 7'h55);
        op(1'b0, 1'b1, 7'h55);
        instr_i = 1'b0;
        chk(15'(cnt[14:8]), 15'(snap[14:8]), "void refresh");
        for (int i = 0; i < 2; i++)
        begin
            idle_i = (i == 0);
            pd_i = (i == 1);
            tick(2);
            snap = cnt;
            tick(60);
            chk(cnt, snap, "halted count");
            idle_i = 1'b0;
            pd_i = 1'b0;
        end
        op(1'b1, 1'b0, 7'h7f);
        op(1'b0, 1'b1, 7'h7f);
        instr_i = 1'b0;
        chk(cnt, 15'h7f00, "top reload");
        settle(4000, 2, 1'b1);
        chk_bit((n >= 3060) && (n <= 3090), 1'b1, "overflow time");
        chk_bit(flag, 1'b1, "watchdog flag");
        tick();
        chk(15'({wdt_rst, running}), 15'h0000, "one pulse, stopped");
        chk(cnt, 15'h0000, "count cleared");
        ext_reset_i = 1'b1;
        tick();
        ext_reset_i = 1'b0;
        tick();
        chk_bit(flag, 1'b0, "external reset flag");
        pin_n = 1'b0;
        settle(10, 3, 1'b1);
        chk_bit(running, 1'b1, "pin start");
        pin_n = 1'b1;
    endtask

    task automatic conclude();
        $display("errors %0d of %0d checks", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard well beyond the expected run
    initial
    begin
        #(20000 * 40);
        num_errors++;
        conclude();
    end

    initial
    begin
        repeat (4) @(posedge clk_i);
        #2;
        chk(cnt, 15'h0000, "reset count");
        chk(15'({running, flag}), 15'h0000, "reset state");
        chk(15'({osc_rst, sel_rc}), 15'h0003, "rc reset at power-on");
        rst_n_i = 1'b1;
        t_osc();
        t_wdt();
        conclude();
    end
endmodule
`default_nettype wire
